// ==== utp_pkg.sv ====
package utp_pkg;
	// clock figures
	localparam int REF_CLK_MHZ     = 40;
	localparam int TX_LINK_MAX_MHZ = 25;
	// fastest legal half period of the transmit link clock, in reference cycles
	localparam int TX_HALF_RAW     = (REF_CLK_MHZ + 2 * TX_LINK_MAX_MHZ - 1)
	                                 / (2 * TX_LINK_MAX_MHZ);
	localparam int TX_HALF_MIN     = (TX_HALF_RAW < 1) ? 1 : TX_HALF_RAW;
	// cell framing
	localparam int CELL_BYTES      = 53;
	localparam int IDX_W           = 6;
	localparam logic [IDX_W-1:0] IDX_ZERO = 6'h00;
	localparam logic [IDX_W-1:0] IDX_ONE  = 6'h01;
	localparam logic [IDX_W-1:0] IDX_LAST = 6'h34;
	localparam logic [IDX_W-1:0] IDX_FULL = 6'h35;
	// rate select width and fifo defaults
	localparam int RATE_W          = 4;
	localparam int SEG_FIFO_DEPTH  = 32;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// one byte of a cell with its start marker
	typedef struct packed {
		logic       soc;
		logic [7:0] data;
	} utp_byte_t;

	localparam int BYTE_T_W = $bits(utp_byte_t);

	// transmit merge states, gray along idle -> seg -> aux
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SEG  = 2'b01,
		TX_AUX  = 2'b11
	} utp_tx_state_t;
endpackage

// ==== utp_fifo.sv ====
`timescale 1ns/1ps
module utp_fifo
	import utp_pkg::*;
#(
	parameter int WIDTH = BYTE_T_W,
	parameter int DEPTH = SEG_FIFO_DEPTH
)(
	input  wire logic             i_clk,     // reference clock
	input  wire logic             i_rst,     // async reset, high
	input  wire logic             i_wvalid,  // write side valid
	input  wire logic [WIDTH-1:0] i_wdata,   // write word
	output logic                  o_wready,  // not full
	output logic                  o_rvalid,  // not empty
	output logic [WIDTH-1:0]      o_rdata,   // head word
	input  wire logic             i_rready   // read side pop
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_DEPTH = (AW+1)'(DEPTH);
	localparam logic [AW:0] CNT_ONE   = (AW+1)'(1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr, rptr, next_wptr, next_rptr;
	logic [AW:0]      cnt, next_cnt;
	logic             next_full, next_empty, full, empty, push, pop;
	logic             room;

	// pointer, count and registered flags
	always_comb
	begin
		push       = i_wvalid && !full;
		pop        = i_rready && !empty;
		next_wptr  = push ? AW'(wptr + 1'b1) : wptr;
		next_rptr  = pop ? AW'(rptr + 1'b1) : rptr;
		next_cnt   = cnt;
		if (push && !pop)
			next_cnt = cnt + CNT_ONE;
		else if (pop && !push)
			next_cnt = cnt - CNT_ONE;
		next_full  = (next_cnt == CNT_DEPTH);
		next_empty = (next_cnt == '0);
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wptr  <= '0;
			rptr  <= '0;
			cnt   <= '0;
			full  <= 1'b0;
			empty <= 1'b1;
			room  <= 1'b1;
		end
		else
		begin
			wptr  <= next_wptr;
			rptr  <= next_rptr;
			cnt   <= next_cnt;
			full  <= next_full;
			empty <= next_empty;
			room  <= !next_full;
		end
	end

	// storage, no reset needed
	always_ff @(posedge i_clk)
	begin
		if (push)
			mem[wptr] <= i_wdata;
	end

	assign o_wready = room;
	assign o_rvalid = !empty;
	assign o_rdata  = mem[rptr];
endmodule

// ==== utp_cell_ports.sv ====
`timescale 1ns/1ps
// Function
// R1: transmit byte bus carries each cell byte, bit 7 most significant.
// R2: transmit cell start high exactly with the first byte of a cell.
// R3: transmit valid_n low while data valid, high otherwise.
// R4: start a transmit cell only while the phy room flag is high.
// R5: transmit link clock made here, selectable rate, at most 25 MHz.
// R6: transmit parity is odd parity over the eight data bits.
// R7: phy drives received bytes on receive bus, bit 7 most significant.
// R8: phy marks first received byte with receive cell start.
// R9: receive signals sampled at the link edge after enable_n low.
// R10: receive enable_n may be held low permanently.
// R11: phy raises cell ready when a whole cell waits.
// R12: receive link clock comes from outside, or from our transmit clock; here only the external i_main_rx_link_clock is used.
// R13: external sar drives aux bytes, bit 7 most significant.
// R14: external sar marks first aux byte with aux cell start.
// R15: aux bytes captured only while aux valid_n is low.
// R16: aux room flag high only while a whole cell fits.
// R17: aux transfers ride the externally supplied aux link clock.
// R18: aux port behaves as a phy toward the external sar.
// R19: merge segmenter and aux cells; segmenter equal or higher priority.
// R20: each cell is 53 contiguous bytes from its start byte; a segmenter cell pauses, valid_n high, while the fifo is empty.
// R21: each link sampled or generated, crossed safely into reference clock.
module utp_cell_ports
	import utp_pkg::*;
#(
	parameter int FIFO_DEPTH = SEG_FIFO_DEPTH
)(
	input  wire logic              i_ref_clk,            // 40 MHz reference
	input  wire logic              i_rst,                // async reset, high
	input  wire logic [RATE_W-1:0] i_tx_rate_sel,        // tx clock half period - min
	input  wire logic              i_seg_high_prio,      // 1: segmenter wins
	input  wire logic              i_seg_valid,          // segmenter byte valid
	input  wire utp_byte_t         i_seg_byte,           // segmenter byte
	output logic                   o_seg_ready,          // fifo has room
	output logic [7:0]             o_main_tx_byte_bus,   // to phy
	output logic                   o_main_tx_cell_start, // first byte marker
	output logic                   o_main_tx_valid_n,    // low = data valid
	output logic                   o_main_tx_odd_parity, // odd parity
	output logic                   o_main_tx_link_clock, // generated clock
	input  wire logic              i_main_tx_room_flag,  // phy can take a cell
	input  wire logic [7:0]        i_main_rx_byte_bus,   // from phy
	input  wire logic              i_main_rx_cell_start, // first byte marker
	input  wire logic              i_main_rx_enable_n,   // low = sample next
	input  wire logic              i_main_rx_cell_ready, // phy has a cell
	input  wire logic              i_main_rx_link_clock, // receive clock
	output utp_byte_t              o_rx_byte,            // received byte
	output logic                   o_rx_valid,           // one-cycle pulse
	output logic                   o_rx_cell_ready,      // synced cell ready
	input  wire logic [7:0]        i_aux_in_byte_bus,    // from external sar
	input  wire logic              i_aux_in_cell_start,  // first byte marker
	input  wire logic              i_aux_in_valid_n,     // low = data valid
	input  wire logic              i_aux_in_link_clock,  // aux clock
	output logic                   o_aux_in_room_flag    // room for a cell
);
	localparam int SW = 24;

	// two-flop synchronisers for every pin input
	logic [SW-1:0] s1, s2;
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s1 <= '0;
			s2 <= '0;
		end
		else
		begin
			s1 <= {i_main_rx_link_clock, i_main_rx_enable_n, i_main_rx_cell_start,
			       i_main_rx_cell_ready, i_main_rx_byte_bus, i_aux_in_link_clock,
			       i_aux_in_valid_n, i_aux_in_cell_start, i_aux_in_byte_bus,
			       i_main_tx_room_flag};
			s2 <= s1;
		end
	end

	logic       rx_clk_s, rx_en_n_s, rx_soc_s, rx_rdy_s, aux_clk_s, aux_vn_s, aux_soc_s;
	logic       room_s;
	logic [7:0] rx_dat_s, aux_dat_s;
	assign {rx_clk_s, rx_en_n_s, rx_soc_s, rx_rdy_s, rx_dat_s, aux_clk_s,
	        aux_vn_s, aux_soc_s, aux_dat_s, room_s} = s2;

	// edge detection on synchronised link clocks
	logic rx_clk_d, aux_clk_d, rx_rise, aux_rise;
	assign rx_rise  = rx_clk_s && !rx_clk_d;  // R21
	assign aux_rise = aux_clk_s && !aux_clk_d; // R17

	// receive path: sample one link edge after enable_n seen low
	logic      rx_en_prev_n, next_rx_en_prev_n, next_rx_valid;
	utp_byte_t next_rx_byte;
	always_comb
	begin
		next_rx_en_prev_n = rx_rise ? rx_en_n_s : rx_en_prev_n;      // R9 R10
		next_rx_valid     = rx_rise && !rx_en_prev_n;                // R9
		next_rx_byte      = next_rx_valid ? utp_byte_t'{soc: rx_soc_s, data: rx_dat_s}
		                                  : o_rx_byte; // R7 R8
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			rx_clk_d        <= 1'b0;
			aux_clk_d       <= 1'b0;
			rx_en_prev_n    <= 1'b1;
			o_rx_valid      <= 1'b0;
			o_rx_byte       <= '0;
			o_rx_cell_ready <= 1'b0;
		end
		else
		begin
			rx_clk_d        <= rx_clk_s;
			aux_clk_d       <= aux_clk_s;
			rx_en_prev_n    <= next_rx_en_prev_n;
			o_rx_valid      <= next_rx_valid;
			o_rx_byte       <= next_rx_byte;
			o_rx_cell_ready <= rx_rdy_s; // R11
		end
	end

	// aux port: phy-like cell buffer, filled on the sar's clock edges
	logic [7:0]       aux_buf [CELL_BYTES];
	logic [IDX_W-1:0] aux_wr_idx, next_aux_wr_idx, tx_idx, next_tx_idx;
	logic             aux_full, next_aux_full, aux_we, aux_done;
	logic [IDX_W-1:0] aux_waddr;
	always_comb
	begin
		aux_we          = 1'b0;
		aux_waddr       = aux_wr_idx;
		next_aux_wr_idx = aux_wr_idx;
		next_aux_full   = aux_full;
		if (aux_rise && !aux_vn_s && !aux_full)                // R15 R18
		begin
			aux_we = 1'b1;
			if (aux_soc_s)                                     // R14
				aux_waddr = IDX_ZERO;
			next_aux_wr_idx = aux_waddr + IDX_ONE;
			if (next_aux_wr_idx == IDX_FULL)                   // R20
				next_aux_full = 1'b1;
		end
		if (aux_done)
		begin
			next_aux_full   = 1'b0;
			next_aux_wr_idx = IDX_ZERO;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (aux_we)
			aux_buf[aux_waddr] <= aux_dat_s;                   // R13
	end

	// segmenter fifo
	logic      fifo_rvalid, fifo_pop;
	utp_byte_t fifo_head;
	utp_fifo #(.WIDTH(BYTE_T_W), .DEPTH(FIFO_DEPTH)) u_seg_fifo (
		.i_clk    (i_ref_clk),
		.i_rst    (i_rst),
		.i_wvalid (i_seg_valid),
		.i_wdata  (i_seg_byte),
		.o_wready (o_seg_ready),
		.o_rvalid (fifo_rvalid),
		.o_rdata  (fifo_head),
		.i_rready (fifo_pop)
	);

	// transmit clock divider
	logic [RATE_W:0] div_cnt, next_div_cnt, half_m1;
	logic            next_tx_clk, fall_tick;
	always_comb
	begin
		half_m1      = (RATE_W+1)'(TX_HALF_MIN - 1) + {1'b0, i_tx_rate_sel}; // R5
		fall_tick    = 1'b0;
		next_tx_clk  = o_main_tx_link_clock;
		next_div_cnt = div_cnt + 1'b1;
		if (div_cnt >= half_m1)
		begin
			next_div_cnt = '0;
			next_tx_clk  = !o_main_tx_link_clock;
			fall_tick    = o_main_tx_link_clock;
		end
	end

	// transmit merge and byte emission, updated as the link clock falls
	utp_tx_state_t tx_st, next_tx_st;
	logic          last_aux, next_last_aux, pick_seg, pick_aux, seg_cell;
	logic          next_soc, next_vn;
	logic [7:0]    next_data;
	always_comb
	begin
		next_tx_st    = tx_st;
		next_tx_idx   = tx_idx;
		next_last_aux = last_aux;
		next_soc      = 1'b0;
		next_vn       = 1'b1;                                  // R3
		next_data     = o_main_tx_byte_bus;
		fifo_pop      = 1'b0;
		aux_done      = 1'b0;
		seg_cell      = fifo_rvalid && fifo_head.soc;
		pick_seg      = seg_cell && (!aux_full || i_seg_high_prio || last_aux); // R19
		pick_aux      = aux_full && !pick_seg;
		if (fall_tick)
		begin
			case (tx_st)
				TX_IDLE:
				begin
					if (fifo_rvalid && !fifo_head.soc)
						fifo_pop = 1'b1;                       // drop stray bytes
					else if (room_s && pick_seg)               // R4
					begin
						fifo_pop   = 1'b1;
						next_data  = fifo_head.data;           // R1
						next_soc   = 1'b1;                     // R2
						next_vn    = 1'b0;
						next_tx_idx   = IDX_ONE;
						next_tx_st    = TX_SEG;
						next_last_aux = 1'b0;
					end
					else if (room_s && pick_aux)               // R4
					begin
						next_data  = aux_buf[IDX_ZERO];
						next_soc   = 1'b1;                     // R2
						next_vn    = 1'b0;
						next_tx_idx   = IDX_ONE;
						next_tx_st    = TX_AUX;
						next_last_aux = 1'b1;
					end
				end
				TX_SEG:
				begin
					if (fifo_rvalid)
					begin
						fifo_pop    = 1'b1;
						next_data   = fifo_head.data;          // R1
						next_vn     = 1'b0;
						next_tx_idx = tx_idx + IDX_ONE;
						if (tx_idx == IDX_LAST)                // R20
							next_tx_st = TX_IDLE;
					end
				end
				TX_AUX:
				begin
					next_data   = aux_buf[tx_idx];
					next_vn     = 1'b0;
					next_tx_idx = tx_idx + IDX_ONE;
					if (tx_idx == IDX_LAST)                    // R20
					begin
						next_tx_st = TX_IDLE;
						aux_done   = 1'b1;                     // R16
					end
				end
				default:
					next_tx_st = TX_IDLE;
			endcase
		end
		else
		begin
			next_soc = o_main_tx_cell_start;
			next_vn  = o_main_tx_valid_n;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			div_cnt              <= '0;
			o_main_tx_link_clock <= 1'b0;
			tx_st                <= TX_IDLE;
			tx_idx               <= IDX_ZERO;
			last_aux             <= 1'b0;
			aux_wr_idx           <= IDX_ZERO;
			aux_full             <= 1'b0;
			o_aux_in_room_flag   <= 1'b0;
			o_main_tx_byte_bus   <= BYTE_ZERO;
			o_main_tx_cell_start <= 1'b0;
			o_main_tx_valid_n    <= 1'b1;
			o_main_tx_odd_parity <= 1'b1;
		end
		else
		begin
			div_cnt              <= next_div_cnt;
			o_main_tx_link_clock <= next_tx_clk;
			tx_st                <= next_tx_st;
			tx_idx               <= next_tx_idx;
			last_aux             <= next_last_aux;
			aux_wr_idx           <= next_aux_wr_idx;
			aux_full             <= next_aux_full;
			o_aux_in_room_flag   <= !next_aux_full;           // R16
			o_main_tx_byte_bus   <= next_data;
			o_main_tx_cell_start <= next_soc;
			o_main_tx_valid_n    <= next_vn;
			o_main_tx_odd_parity <= ~^next_data;              // R6
		end
	end

	// helper: bytes sent since the last cell start
	logic [IDX_W-1:0] sent_cnt;
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			sent_cnt <= IDX_ZERO;
		else if (fall_tick && !next_vn)
			sent_cnt <= next_soc ? IDX_ONE : sent_cnt + IDX_ONE;
	end

	sequence aux_last_write;
		aux_we ##0 (next_aux_wr_idx == IDX_FULL);
	endsequence
	sequence both_pending_hi;
		fall_tick && (tx_st == TX_IDLE) && room_s && seg_cell && aux_full && i_seg_high_prio;
	endsequence

	tx_parity_odd_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R6
		^{o_main_tx_odd_parity, o_main_tx_byte_bus} == 1'b1)
		else $error("tx parity not odd");
	tx_soc_valid_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
		o_main_tx_cell_start |-> !o_main_tx_valid_n)
		else $error("cell start without valid data");
	tx_start_room_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
		$rose(o_main_tx_cell_start) |-> $past(room_s))
		else $error("cell started without phy room");
	tx_cell_len_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R20
		(fall_tick && next_soc && !next_vn) |-> (sent_cnt == IDX_ZERO || sent_cnt == IDX_FULL))
		else $error("cell start before previous cell ended");
	tx_count_max_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R20
		sent_cnt <= IDX_FULL)
		else $error("cell longer than 53 bytes");
	tx_data_timing_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
		$changed(o_main_tx_byte_bus) |-> !o_main_tx_link_clock && $past(o_main_tx_link_clock))
		else $error("tx data changed away from falling clock");
	aux_room_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R16
		aux_last_write |=> !o_aux_in_room_flag)
		else $error("room flag still high with full buffer");
	aux_capture_en_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R15
		aux_we |-> !aux_vn_s && aux_rise)
		else $error("aux byte captured without enable");
	rx_sample_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R9
		o_rx_valid |-> $past(rx_rise) && !$past(rx_en_prev_n)
		&& o_rx_byte.data == $past(rx_dat_s))
		else $error("rx byte sampled at wrong edge");
	merge_prio_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R19
		both_pending_hi |=> (tx_st == TX_SEG))
		else $error("high priority segmenter cell not chosen");
endmodule

// ==== utp_link_partner.sv ====
`timescale 1ns/1ps
module utp_link_partner
	import utp_pkg::*;
(
	input  wire logic       i_tx_clk,      // generated tx link clock
	input  wire logic [7:0] i_tx_bus,      // tx byte bus
	input  wire logic       i_tx_start,    // tx cell start
	input  wire logic       i_tx_valid_n,  // tx valid, low active
	input  wire logic       i_tx_par,      // tx odd parity
	input  wire logic       i_room_en,     // bench lets a cell in
	input  wire logic       i_aux_room,    // device room for aux cell
	output logic            o_room,        // phy can take a cell
	output logic [7:0]      o_rx_bus,      // rx byte bus
	output logic            o_rx_start,    // rx cell start
	output logic            o_rx_en_n,     // rx enable, low active
	output logic            o_rx_ready,    // phy has a cell
	output logic            o_rx_clk,      // rx link clock
	output logic [7:0]      o_aux_bus,     // aux byte bus
	output logic            o_aux_start,   // aux cell start
	output logic            o_aux_valid_n, // aux valid, low active
	output logic            o_aux_clk      // aux link clock
);
	logic [9:0] got [$];
	// room flag only while the bench can take a whole cell
	assign o_room = i_room_en;
	// capture each valid byte with a parity-good bit on top
	always @(posedge i_tx_clk)
		if (i_tx_valid_n == 1'b0)
			got.push_back({i_tx_par ^ (^i_tx_bus), i_tx_start, i_tx_bus});
	// idle levels, clocks stand still between frames
	initial
	begin
		o_rx_bus = 8'h00;
		o_rx_start = 1'b0;
		o_rx_en_n = 1'b1;
		o_rx_ready = 1'b0;
		o_rx_clk = 1'b0;
		o_aux_bus = 8'h00;
		o_aux_start = 1'b0;
		o_aux_valid_n = 1'b1;
		o_aux_clk = 1'b0;
	end
	// one receive cell, 200 ns link clock, bytes change on the falling edge
	task automatic rx_cell(input logic [7:0] base);
		o_rx_ready = 1'b1;
		o_rx_en_n = 1'b0;
		#100 o_rx_clk = 1'b1;
		for (int k = 0; k < CELL_BYTES; k++)
		begin
			#100 o_rx_clk = 1'b0;
			o_rx_bus = base + 8'(k);
			o_rx_start = (k == 0);
			o_rx_en_n = (k == CELL_BYTES - 1);
			#100 o_rx_clk = 1'b1;
		end
		#100 o_rx_clk = 1'b0;
		o_rx_bus = ~o_rx_bus;
		o_rx_start = 1'b0;
		o_rx_ready = 1'b0;
	endtask
	// one aux cell, sent once the device shows room, or anyway after 400 waits of 25 ns
	task automatic aux_cell(input logic [7:0] base);
		for (int w = 0; w < 400 && i_aux_room !== 1'b1; w++)
			#25;
		for (int k = 0; k < CELL_BYTES; k++)
		begin
			#100 o_aux_clk = 1'b0;
			o_aux_bus = base + 8'(k);
			o_aux_start = (k == 0);
			o_aux_valid_n = 1'b0;
			#100 o_aux_clk = 1'b1;
		end
		#100 o_aux_clk = 1'b0;
		o_aux_bus = ~o_aux_bus;
		o_aux_start = 1'b0;
		o_aux_valid_n = 1'b1;
	endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
	import utp_pkg::*;
	logic       clk, rst, prio, seg_valid, room_en, tx_clk, tx_soc, tx_vn, tx_par, room;
	logic       rx_soc, rx_en_n, rx_rdy, rx_clk, rx_valid, rx_cr;
	logic       aux_soc, aux_vn, aux_clk, aux_room, seg_ready;
	logic [7:0] tx_bus, rx_bus, aux_bus;
	logic [3:0] rate_sel;
	utp_byte_t  seg_byte, rx_byte;
	int         mismatches, checked;

	utp_cell_ports #(.FIFO_DEPTH(32)) utp_cell_ports_i (.i_ref_clk(clk), .i_rst(rst),
		.i_tx_rate_sel(rate_sel), .i_seg_high_prio(prio), .i_seg_valid(seg_valid),
		.i_seg_byte(seg_byte), .o_seg_ready(seg_ready), .o_main_tx_byte_bus(tx_bus),
		.o_main_tx_cell_start(tx_soc), .o_main_tx_valid_n(tx_vn),
		.o_main_tx_odd_parity(tx_par), .o_main_tx_link_clock(tx_clk),
		.i_main_tx_room_flag(room), .i_main_rx_byte_bus(rx_bus),
		.i_main_rx_cell_start(rx_soc), .i_main_rx_enable_n(rx_en_n),
		.i_main_rx_cell_ready(rx_rdy), .i_main_rx_link_clock(rx_clk), .o_rx_byte(rx_byte),
		.o_rx_valid(rx_valid), .o_rx_cell_ready(rx_cr), .i_aux_in_byte_bus(aux_bus),
		.i_aux_in_cell_start(aux_soc), .i_aux_in_valid_n(aux_vn),
		.i_aux_in_link_clock(aux_clk), .o_aux_in_room_flag(aux_room));
	utp_link_partner utp_link_partner_i (.i_tx_clk(tx_clk), .i_tx_bus(tx_bus),
		.i_tx_start(tx_soc), .i_tx_valid_n(tx_vn), .i_tx_par(tx_par), .i_room_en(room_en),
		.i_aux_room(aux_room), .o_room(room), .o_rx_bus(rx_bus), .o_rx_start(rx_soc),
		.o_rx_en_n(rx_en_n), .o_rx_ready(rx_rdy), .o_rx_clk(rx_clk), .o_aux_bus(aux_bus),
		.o_aux_start(aux_soc), .o_aux_valid_n(aux_vn), .o_aux_clk(aux_clk));

	// 40 MHz reference
	always #12.5 clk = ~clk;

	task automatic final_report;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// bounded wait ran out: counted, then straight to the verdict
	task automatic ran_out;
		mismatches++;
		$display("mismatch t=%0t wait ran out got %h exp %h", $time, 1'b0, 1'b1);
		final_report();
	endtask
	// offer one segmenter word and hold it until taken
	task automatic push(input logic soc, input logic [7:0] data);
		int n = 0;
		seg_valid = 1'b1;
		seg_byte.soc = soc;
		seg_byte.data = data;
		@(posedge clk);
		while (seg_ready !== 1'b1 && n < 2000)
		begin
			n++;
			@(posedge clk);
		end
		if (n == 2000)
			ran_out();
		#1;
	endtask
	// wait for a whole cell at the phy and compare every byte
	task automatic tx_cell(input logic [7:0] base);
		logic [9:0] e;
		for (int n = 0; utp_link_partner_i.got.size() < CELL_BYTES; n++)
		begin
			if (n == 4000)
				ran_out();
			@(posedge clk);
		end
		for (int k = 0; k < CELL_BYTES; k++)
		begin
			e = {1'b1, k == 0, base + 8'(k)};
			chk(utp_link_partner_i.got.pop_front(), e);
		end
		#1;
	endtask
	task automatic test_reset;
		int n = 0;
		repeat (3) @(posedge clk);
		#1;
		chk({9'h0, tx_vn}, 10'h1);
		chk({9'h0, aux_room}, 10'h1);
		chk({9'h0, rx_valid}, 10'h0);
		// two-cycle half period: four high samples in any eight
		repeat (8)
		begin
			@(posedge clk);
			#1 n += int'(tx_clk);
		end
		chk(10'(n), 10'h4);
		$display("test reset done");
	endtask
	task automatic test_seg_cell;
		room_en = 1'b1;
		for (int k = 0; k < CELL_BYTES; k++)
			push(k == 0, 8'h10 + 8'(k));
		seg_valid = 1'b0;
		tx_cell(8'h10);
		repeat (20) @(posedge clk);
		#1 chk({9'h0, tx_vn}, 10'h1);
		$display("test seg_cell done");
	endtask
	// phy stalls: fifo fills, an aux cell waits too; then segmenter wins
	task automatic test_room_hold;
		room_en = 1'b0;
		for (int k = 0; k < 32; k++)
			push(k == 0, 8'h80 + 8'(k));
		seg_valid = 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({9'h0, seg_ready}, 10'h0);
		utp_link_partner_i.aux_cell(8'h20);
		repeat (300) @(posedge clk);
		#1 chk(10'(utp_link_partner_i.got.size()), 10'h0);
		chk({9'h0, aux_room}, 10'h0);
		room_en = 1'b1;
		for (int k = 32; k < CELL_BYTES; k++)
			push(1'b0, 8'h80 + 8'(k));
		seg_valid = 1'b0;
		tx_cell(8'h80);
		tx_cell(8'h20);
		$display("test room_hold done");
	endtask
	task automatic test_rx;
		int n = 0;
		fork
			utp_link_partner_i.rx_cell(8'h40);
			repeat (700)
			begin
				@(posedge clk);
				#1;
				if (rx_valid === 1'b1)
				begin
					if (n == 0)
						chk({9'h0, rx_cr}, 10'h1);
					chk({1'b0, rx_byte}, {1'b0, n == 0, 8'h40 + 8'(n)});
					n++;
				end
			end
		join
		chk(10'(n), 10'(CELL_BYTES));
		chk({9'h0, rx_cr}, 10'h0);
		$display("test rx done");
	endtask
	task automatic test_aux;
		prio = 1'b0;
		utp_link_partner_i.aux_cell(8'hc0);
		repeat (8) @(posedge clk);
		#1 chk({9'h0, aux_room}, 10'h0);
		tx_cell(8'hc0);
		repeat (10) @(posedge clk);
		#1 chk({9'h0, aux_room}, 10'h1);
		$display("test aux done");
	endtask
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		prio = 1'b1;
		seg_valid = 1'b0;
		seg_byte = '0;
		room_en = 1'b0;
		rate_sel = 4'h1;
		mismatches = 0;
		checked = 0;
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		test_reset();
		test_seg_cell();
		test_room_hold();
		test_rx();
		test_aux();
		final_report();
	end
endmodule
